// [include/fps_regs.vh]
// register offsets, field positions, reset values and timing counts for flash protect/status
`ifndef FPS_REGS_VH
`define FPS_REGS_VH
`define FPS_OFF_PROT 5'h00
`define FPS_OFF_STAT 5'h04
`define FPS_OFF_CMD 5'h08
`define FPS_OFF_ADDR 5'h0c
`define FPS_OFF_IMASK 5'h10
`define FPS_OFF_ISTAT 5'h14
`define FPS_BIT_CBEF 7
`define FPS_BIT_CCF 6
`define FPS_BIT_PVIOL 5
`define FPS_BIT_ACCERR 4
`define FPS_BIT_BLANK 2
`define FPS_BIT_POPEN 0
`define FPS_CMD_EVERIFY 7'h05
`define FPS_CMD_PROG 7'h20
`define FPS_CMD_BURST 7'h25
`define FPS_CMD_SERASE 7'h40
`define FPS_CMD_MERASE 7'h41
`define FPS_PROT_NONE 7'h7f
`define FPS_PROT_HALF 7'h3f
`define FPS_RST_STAT 8'hc0
`define FPS_RST_IMASK 3'h0
`define FPS_PROG_CYC 16'h0009
`define FPS_BURST_CYC 16'h0004
`define FPS_SERASE_CYC 16'h0fa0
`define FPS_MERASE_CYC 16'h4e20
`define FPS_EVERIFY_CYC 16'h0010
`endif

// [core/fps_flash_protect_status.v]
// flash protection range and status flags block with axi4-lite registers
// Behaviour
// (R1) protection writes only accepted when region grows; the code also accepts a write that keeps the protected region the same size
// (R2) protection loaded from nonvolatile byte after reset
// (R3) protected program/erase sets violation flag
// (R4) mass erase refused while anything protected
// (R5) open bit clear protects whole array
// (R6) size field protects 127 minus field Kbytes
// (R7) status bit access: rw, read-only, zeros
// (R8) buffer empty sets when sequence may start
// (R9) zero to buffer-empty mid sequence aborts, errors
// (R10) complete clears at launch, sets when done
// (R11) complete stays low across burst fetch
// (R12) violation cleared by one; blocks sequences
// (R13) access error on sequence, code, stop
// (R14) access error cleared by one; blocks sequences
// (R15) blank flag reflects erase verify result
// (R16) blank cleared on valid launch; read-only
// (R17) software keeps address, command, launch order
// (R18) only five command codes accepted
// (R19) launch compares address against decoded range
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`include "fps_regs.vh"
module fps_flash_protect_status #(
	parameter ADDR_W = 17,
	parameter CYC_W = 16
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write address
	input wire [4:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [4:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// flash array side
	input wire [7:0] nonvolatile_protection_byte,
	input wire nv_load_done,
	input wire array_wr,
	input wire [ADDR_W-1:0] array_wr_addr,
	input wire info_row_sel,
	input wire erase_verify_blank,
	input wire stop_req,
	// nvm engine command outputs
	output reg cmd_start,
	output reg [6:0] cmd_code,
	output reg [ADDR_W-1:0] cmd_addr,
	// interrupt
	output wire irq
);
	localparam SQ_IDLE = 2'd0;
	localparam SQ_ADDR = 2'd1;
	localparam SQ_CMD = 2'd2;
	localparam EX_IDLE = 2'd0;
	localparam EX_RUN = 2'd1;

	// array-side inputs are from the same clock domain except stop and nv done
	reg stop_s1_r, stop_s2_r, stop_s3_r, nvd_s1_r, nvd_s2_r, nv_loaded_r;

	reg [7:0] flash_protection_range_r;
	reg cbef_r, ccf_r, pviol_r, accerr_r, blank_r;
	reg [1:0] seq_r;
	reg [6:0] command_code_register_r;
	reg [ADDR_W-1:0] seq_addr_r;
	reg seq_info_r;
	reg [1:0] ex_r;
	reg pend_r;
	reg [6:0] pend_code_r;
	reg [ADDR_W-1:0] pend_addr_r;
	reg [CYC_W-1:0] cnt_r;
	reg [2:0] imask_r, istat_r;

	// protected start in flipped-half order: everything at and above it is protected
	function [ADDR_W:0] prot_base;
		input [7:0] p;
		begin
			if (!p[`FPS_BIT_POPEN])
				prot_base = {(ADDR_W+1){1'b0}}; // (R5)
			else
				prot_base = ({{(ADDR_W-6){1'b0}}, p[7:1]} + 1'b1) << 10; // (R6)
		end
	endfunction

	function is_prot;
		input [7:0] p;
		input [ADDR_W-1:0] a;
		input information_row;
		begin
			// the upper array's base is unprotected first, so flipping the top
			// address bit turns both halves into one compare against the base
			is_prot = information_row ? !p[`FPS_BIT_POPEN] || (p[7:1] != `FPS_PROT_NONE)
				: ({1'b0, ~a[ADDR_W-1], a[ADDR_W-2:0]} >= prot_base(p)); // (R6) (R19)
		end
	endfunction

	function valid_cmd;
		input [6:0] c;
		begin
			case (c) // (R18)
			`FPS_CMD_EVERIFY, `FPS_CMD_PROG, `FPS_CMD_BURST, `FPS_CMD_SERASE,
			`FPS_CMD_MERASE: valid_cmd = 1'b1;
			default: valid_cmd = 1'b0;
			endcase
		end
	endfunction

	function [CYC_W-1:0] cmd_cycles;
		input [6:0] c;
		begin
			case (c)
			`FPS_CMD_PROG: cmd_cycles = `FPS_PROG_CYC;
			`FPS_CMD_BURST: cmd_cycles = `FPS_BURST_CYC;
			`FPS_CMD_SERASE: cmd_cycles = `FPS_SERASE_CYC;
			`FPS_CMD_MERASE: cmd_cycles = `FPS_MERASE_CYC;
			default: cmd_cycles = `FPS_EVERIFY_CYC;
			endcase
		end
	endfunction

	// offsets that answer okay; anything else gets a slave error
	function reg_mapped;
		input [4:0] a;
		begin
			case (a)
			`FPS_OFF_PROT, `FPS_OFF_STAT, `FPS_OFF_CMD, `FPS_OFF_ADDR, `FPS_OFF_IMASK,
			`FPS_OFF_ISTAT: reg_mapped = 1'b1;
			default: reg_mapped = 1'b0;
			endcase
		end
	endfunction

	// axi write: take address and data in either order, answer when both held
	reg aw_got_r, w_got_r;
	reg [4:0] aw_addr_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;
	assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
	assign s_axi_wready = !w_got_r && !s_axi_bvalid;
	wire wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
	wire wr_b0 = wr_go && w_strb_r[0];
	wire wr_prot = wr_b0 && aw_addr_r == `FPS_OFF_PROT;
	wire wr_stat = wr_b0 && aw_addr_r == `FPS_OFF_STAT;
	wire wr_cmd = wr_b0 && aw_addr_r == `FPS_OFF_CMD;
	wire wr_imask = wr_b0 && aw_addr_r == `FPS_OFF_IMASK;
	wire wr_istat = wr_b0 && aw_addr_r == `FPS_OFF_ISTAT;
	wire wr_map = reg_mapped(aw_addr_r);
	wire [7:0] wd = w_data_r[7:0];

	// status-write decode
	wire blocked = pviol_r || accerr_r; // (R12) (R14)
	wire launch_w = wr_stat && wd[`FPS_BIT_CBEF];
	wire abort_w = wr_stat && !wd[`FPS_BIT_CBEF] && seq_r != SQ_IDLE; // (R9)
	wire launch_ok = launch_w && seq_r == SQ_CMD && !blocked && cbef_r;
	wire launch_bad = launch_w && seq_r != SQ_CMD && seq_r != SQ_IDLE;
	wire tgt_prot = is_prot(flash_protection_range_r, seq_addr_r, seq_info_r);
	wire all_off = flash_protection_range_r[`FPS_BIT_POPEN] &&
		flash_protection_range_r[7:1] == `FPS_PROT_NONE;
	wire is_alter = command_code_register_r != `FPS_CMD_EVERIFY;
	wire viol = launch_ok && ((command_code_register_r == `FPS_CMD_MERASE && !all_off) ||
		(is_alter && command_code_register_r != `FPS_CMD_MERASE && tgt_prot)); // (R3) (R4)
	wire accept = launch_ok && !viol;
	wire start_seq = array_wr && !blocked && cbef_r && nv_loaded_r; // (R12) (R14)
	wire bad_seq = array_wr && seq_r != SQ_IDLE; // (R13)
	wire bad_code = wr_cmd && seq_r == SQ_ADDR && !valid_cmd(wd[6:0]); // (R18)
	wire cmd_out_of_order = wr_cmd && seq_r != SQ_ADDR;
	// stop request rising while a command still runs
	wire stop_err = stop_s2_r && !stop_s3_r && !ccf_r; // (R13)
	wire acc_set = abort_w || launch_bad || bad_seq || bad_code || cmd_out_of_order ||
		stop_err || (array_wr && !nv_loaded_r);
	wire done = ex_r == EX_RUN && cnt_r == {CYC_W{1'b0}};

	always @(posedge aclk) begin
		if (!aresetn) begin
			stop_s1_r <= 1'b0;
			stop_s2_r <= 1'b0;
			stop_s3_r <= 1'b0;
			nvd_s1_r <= 1'b0;
			nvd_s2_r <= 1'b0;
			nv_loaded_r <= 1'b0;
			flash_protection_range_r <= 8'h00;
		end else begin
			stop_s1_r <= stop_req;
			stop_s2_r <= stop_s1_r;
			stop_s3_r <= stop_s2_r;
			nvd_s1_r <= nv_load_done;
			nvd_s2_r <= nvd_s1_r;
			if (!nv_loaded_r && nvd_s2_r) begin
				flash_protection_range_r <= nonvolatile_protection_byte; // (R2)
				nv_loaded_r <= 1'b1;
			end else if (wr_prot && nv_loaded_r &&
				prot_base(wd) <= prot_base(flash_protection_range_r)) begin
				flash_protection_range_r <= wd; // (R1)
			end
		end
	end

	// command write sequence and execution
	always @(posedge aclk) begin
		if (!aresetn) begin
			seq_r <= SQ_IDLE;
			seq_addr_r <= {ADDR_W{1'b0}};
			seq_info_r <= 1'b0;
			command_code_register_r <= 7'h00;
			cbef_r <= 1'b1;
			ccf_r <= 1'b1;
			pviol_r <= 1'b0;
			accerr_r <= 1'b0;
			blank_r <= 1'b0;
			ex_r <= EX_IDLE;
			pend_r <= 1'b0;
			pend_code_r <= 7'h00;
			pend_addr_r <= {ADDR_W{1'b0}};
			cnt_r <= {CYC_W{1'b0}};
			cmd_start <= 1'b0;
			cmd_code <= 7'h00;
			cmd_addr <= {ADDR_W{1'b0}};
		end else begin
			cmd_start <= 1'b0;
			// sequence tracking
			if (acc_set || viol) begin
				seq_r <= SQ_IDLE;
			end else if (start_seq && seq_r == SQ_IDLE) begin
				seq_r <= SQ_ADDR;
				seq_addr_r <= array_wr_addr;
				seq_info_r <= info_row_sel;
			end else if (wr_cmd && seq_r == SQ_ADDR) begin
				seq_r <= SQ_CMD;
				command_code_register_r <= wd[6:0];
			end else if (launch_ok) begin
				seq_r <= SQ_IDLE;
			end
			// flags: hardware set wins over software clear
			if (viol)
				pviol_r <= 1'b1; // (R3) (R4)
			else if (wr_stat && wd[`FPS_BIT_PVIOL])
				pviol_r <= 1'b0; // (R12)
			if (acc_set)
				accerr_r <= 1'b1; // (R9) (R13)
			else if (wr_stat && wd[`FPS_BIT_ACCERR])
				accerr_r <= 1'b0; // (R14)
			if (accept) begin
				blank_r <= 1'b0; // (R16)
				ccf_r <= 1'b0; // (R10)
				if (ex_r == EX_IDLE) begin
					ex_r <= EX_RUN;
					cnt_r <= cmd_cycles(command_code_register_r);
					cmd_start <= 1'b1;
					cmd_code <= command_code_register_r;
					cmd_addr <= seq_addr_r;
					cbef_r <= 1'b1; // (R8)
				end else begin
					pend_r <= 1'b1;
					pend_code_r <= command_code_register_r;
					pend_addr_r <= seq_addr_r;
					cbef_r <= 1'b0;
				end
			end else if (done) begin
				if (pend_r) begin
					// next buffered burst fetched; complete stays low
					pend_r <= 1'b0;
					cnt_r <= cmd_cycles(pend_code_r);
					cmd_start <= 1'b1;
					cmd_code <= pend_code_r;
					cmd_addr <= pend_addr_r;
					cbef_r <= 1'b1; // (R8) (R11)
				end else begin
					ex_r <= EX_IDLE;
					ccf_r <= 1'b1; // (R10)
					if (cmd_code == `FPS_CMD_EVERIFY)
						blank_r <= erase_verify_blank; // (R15)
				end
			end else if (ex_r == EX_RUN) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end

	// interrupt: events cmd done, violation, access error; write one to clear
	// done only counts once nothing is left to fetch or being buffered
	wire [2:0] ev = {acc_set, viol, done && !pend_r && !accept};
	always @(posedge aclk) begin
		if (!aresetn) begin
			imask_r <= `FPS_RST_IMASK;
			istat_r <= 3'h0;
		end else begin
			if (wr_imask)
				imask_r <= wd[2:0];
			istat_r <= ev | (istat_r & ~(wr_istat ? wd[2:0] : 3'h0));
		end
	end
	// registered so the pin cannot glitch while flags and mask settle
	reg irq_r;
	always @(posedge aclk) begin
		if (!aresetn)
			irq_r <= 1'b0;
		else
			irq_r <= |(istat_r & imask_r);
	end
	assign irq = irq_r;

	wire [7:0] stat_rd = {cbef_r, ccf_r, pviol_r, accerr_r, 1'b0, blank_r, 2'b00}; // (R7)

	// axi write channel state
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_addr_r <= 5'h00;
			w_data_r <= 32'h0;
			w_strb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_r <= 1'b1;
				aw_addr_r <= {s_axi_awaddr[4:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_map ? 2'b00 : 2'b10;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// axi read channel
	assign s_axi_arready = !s_axi_rvalid;
	wire [4:0] ra = {s_axi_araddr[4:2], 2'b00};
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'b00;
			case (ra)
			`FPS_OFF_PROT: s_axi_rdata <= {24'h0, flash_protection_range_r};
			`FPS_OFF_STAT: s_axi_rdata <= {24'h0, stat_rd};
			`FPS_OFF_CMD: s_axi_rdata <= {25'h0, command_code_register_r};
			`FPS_OFF_ADDR: s_axi_rdata <= {{(32-ADDR_W){1'b0}}, seq_addr_r};
			`FPS_OFF_IMASK: s_axi_rdata <= {29'h0, imask_r};
			`FPS_OFF_ISTAT: s_axi_rdata <= {29'h0, istat_r};
			default: begin
				s_axi_rdata <= 32'h0;
				s_axi_rresp <= 2'b10;
			end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// [dv/fps_checker.sv]
// assertion checker on the flash protect/status block ports
`include "fps_regs.vh"
module fps_checker #(
	parameter ADDR_W = 17
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// bus handshakes
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	// command and interrupt
	input wire cmd_start,
	input wire [6:0] cmd_code,
	input wire [ADDR_W-1:0] cmd_addr,
	input wire irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	AST_CMD_VALID: assert property (cmd_start |-> cmd_code inside
		{`FPS_CMD_EVERIFY, `FPS_CMD_PROG, `FPS_CMD_BURST, `FPS_CMD_SERASE, `FPS_CMD_MERASE})
		else $error("illegal command issued");
	AST_START_GAP: assert property (cmd_start |=> !cmd_start [*3])
		else $error("command starts too close");
	AST_CMD_HOLD: assert property (!cmd_start |-> $stable(cmd_code) && $stable(cmd_addr))
		else $error("command changed without start");
	AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during response");
	AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
	AST_QUIET: assert property ($rose(aresetn) |-> !cmd_start && !irq && !s_axi_bvalid)
		else $error("activity right after reset");
endmodule
bind fps_flash_protect_status fps_checker #(.ADDR_W(ADDR_W)) u_chk (.*);

// [dv/fps_flash_protect_status_bench.sv]
// self-checking bench for the flash protect/status block
module fps_flash_protect_status_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, nv_load_done = 0, array_wr = 0;
	logic info_row_sel = 0, erase_verify_blank = 1, stop_req = 0;
	logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, rdat;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic [7:0] nonvolatile_protection_byte = 8'hff;
	logic [16:0] array_wr_addr = 0;
	logic [1:0] lresp;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cmd_start, irq;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [6:0] cmd_code;
	wire [16:0] cmd_addr;
	int num_errors = 0, check_count = 0, cyc = 0, nstart = 0, start_base = 0;
	fps_flash_protect_status u_fps_flash_protect_status (.*);
	always #5 aclk = ~aclk;
	// counts issued command pulses at every edge, so none is missed
	always @(posedge aclk) begin
		if (cmd_start === 1'b1) nstart++;
	end
	task complete_run;
		if (num_errors == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			complete_run;
		end
	end
	task ck(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
		do @(posedge aclk); while (!s_axi_bvalid);
		lresp = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task rd(input logic [4:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (!s_axi_rvalid);
		rdat = s_axi_rdata;
		s_axi_rready <= 0;
	endtask
	task rdck(input logic [4:0] a, input logic [31:0] e);
		rd(a);
		ck(rdat, e);
	endtask
	// address, command, launch in strict order
	task seq(input logic [16:0] a, input logic [6:0] c);
		start_base = nstart;
		@(posedge aclk);
		array_wr <= 1;
		array_wr_addr <= a;
		@(posedge aclk);
		array_wr <= 0;
		wr(5'h08, {1'b0, c});
		wr(5'h04, 8'h80);
	endtask
	task starts(input int n);
		repeat (24) @(posedge aclk);
		ck(nstart - start_base, n);
	endtask
	task t_reset;
		rdck(5'h00, 0);
		rdck(5'h04, 8'hc0);
		nv_load_done <= 1;
		repeat (4) @(posedge aclk);
		rdck(5'h00, 8'hff);
	endtask
	task t_verify;
		seq(17'h0, 7'h05);
		starts(1);
		rdck(5'h04, 8'hc4);
		wr(5'h04, 8'h44);
		rdck(5'h04, 8'hc4);
		erase_verify_blank <= 0;
		seq(17'h0, 7'h05);
		starts(1);
		rdck(5'h04, 8'hc0);
	endtask
	task t_prog;
		logic [6:0] c[3] = '{7'h20, 7'h25, 7'h40};
		foreach (c[i]) begin
			seq(17'h1_0400, c[i]);
			starts(1);
			ck(cmd_code, c[i]);
			ck(cmd_addr, 17'h1_0400);
			rd(5'h04);
			ck(rdat[6], c[i] != 7'h40);
			repeat (4010) @(posedge aclk);
			rdck(5'h04, 8'hc0);
		end
	endtask
	// burst launched while an erase runs waits in the buffer
	task t_burst;
		seq(17'h1_0400, 7'h40);
		seq(17'h1_0800, 7'h25);
		rdck(5'h04, 8'h00);
		do @(posedge aclk); while (cmd_start !== 1'b1);
		rdck(5'h04, 8'h80);
		ck(cmd_code, 7'h25);
		ck(cmd_addr, 17'h1_0800);
		repeat (10) @(posedge aclk);
		rdck(5'h04, 8'hc0);
	endtask
	task t_errors;
		wr(5'h10, 8'h04);
		seq(17'h1_0400, 7'h11);
		starts(0);
		rdck(5'h04, 8'hd0);
		ck(irq, 1);
		seq(17'h1_0400, 7'h20);
		starts(0);
		wr(5'h04, 8'h10);
		wr(5'h14, 8'h04);
		rdck(5'h04, 8'hc0);
		ck(irq, 0);
		@(posedge aclk);
		array_wr <= 1;
		@(posedge aclk);
		array_wr <= 0;
		wr(5'h04, 8'h00);
		rdck(5'h04, 8'hd0);
		wr(5'h04, 8'h10);
		wr(5'h10, 8'h00);
		seq(17'h1_0400, 7'h20);
		stop_req <= 1;
		repeat (24) @(posedge aclk);
		stop_req <= 0;
		rd(5'h04);
		ck(rdat & 8'h10, 8'h10);
		ck(irq, 0);
		wr(5'h04, 8'h10);
	endtask
	task t_prot;
		wr(5'h00, 8'h7f);
		rdck(5'h00, 8'h7f);
		wr(5'h00, 8'hff);
		rdck(5'h00, 8'h7f);
		seq(17'h0_1000, 7'h20);
		starts(0);
		rdck(5'h04, 8'he0);
		seq(17'h1_0400, 7'h20);
		starts(0);
		wr(5'h04, 8'h30);
		rdck(5'h04, 8'hc0);
		seq(17'h1_0400, 7'h41);
		starts(0);
		rdck(5'h04, 8'he0);
		wr(5'h04, 8'h20);
		seq(17'h1_0400, 7'h20);
		starts(1);
		wr(5'h00, 8'h00);
		rdck(5'h00, 8'h00);
		seq(17'h1_fc00, 7'h20);
		starts(0);
		wr(5'h18, 8'h00);
		ck(lresp, 2'h2);
	endtask
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		t_reset;
		t_verify;
		t_prog;
		t_burst;
		t_errors;
		t_prot;
		complete_run;
	end
endmodule
